// [rtl/cct_defs.svh]
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH

// --------------------------------------------------------------------
// Bus geometry
// --------------------------------------------------------------------
`define CCT_AW          10
`define CCT_RESP_OKAY   2'h0
`define CCT_RESP_SLVERR 2'h2

// --------------------------------------------------------------------
// Register indices of the first timer and of the interrupt registers, plus strides (byte address = index * 4)
// --------------------------------------------------------------------
`define CCT_IDX_SC      8'h20
`define CCT_IDX_CNTH    8'h21
`define CCT_IDX_CNTL    8'h22
`define CCT_IDX_MODH    8'h23
`define CCT_IDX_MODL    8'h24
`define CCT_IDX_SC0     8'h25
`define CCT_IDX_CH0H    8'h26
`define CCT_IDX_CH0L    8'h27
`define CCT_TIMER_STRIDE 8'h0b
`define CCT_CH_STRIDE   8'h03
`define CCT_IDX_IRQ_STS 8'h36
`define CCT_IDX_IRQ_MSK 8'h37
`define CCT_IDX_LAST    8'h37

// --------------------------------------------------------------------
// Field positions of the control registers
// --------------------------------------------------------------------
`define CCT_SC_IE       6
`define CCT_SC_STOP     5
`define CCT_SC_RST      4
`define CCT_CH_MSB      5
`define CCT_CH_MSA      4
`define CCT_CH_TOV      1
`define CCT_CH_MAX      0

// --------------------------------------------------------------------
// Reset value, prescaler off code and counts
// --------------------------------------------------------------------
`define CCT_MOD_RESET   16'hffff
`define CCT_PS_OFF      3'h7
`define CCT_NUM_TIMERS  2
`define CCT_NUM_EVENTS  6

`endif

// [rtl/cct_pkg.sv]
package cct_pkg;

	// Channel operating mode
	typedef enum logic [1:0] {
		CCT_CH_OFF,
		CCT_CH_CAPTURE,
		CCT_CH_COMPARE,
		CCT_CH_PWM_BUF
	} cct_chmode_type;

endpackage : cct_pkg

// [rtl/cct_timer.sv]
`timescale 1ns/1ns
`include "cct_defs.svh"


module cct_timer (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [`CCT_AW-1:0]   awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [`CCT_AW-1:0]   araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	input  wire logic [3:0]           port_out,
	input  wire logic [3:0]           port_oe,
	input  wire logic [3:0]           chan_pin_i,
	output logic [3:0]                chan_pin_o,
	output logic [3:0]                chan_pin_oe,
	output logic                      irq
);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic                         wr_fire;
	logic [7:0]                   wr_idx;
	logic [7:0]                   wd;
	logic                         wbe;
	logic [7:0]                   rd_idx;
	logic                         bvalid_reg;
	logic [1:0]                   bresp_reg;
	logic                         rvalid_reg;
	logic [1:0]                   rresp_reg;
	logic [31:0]                  rdata_reg;
	logic [7:0]                   rd_tm [`CCT_NUM_TIMERS];
	logic [7:0]                   rd_ch [4];
	logic [7:0]                   rd_byte;
	logic [`CCT_NUM_EVENTS-1:0]   sts_reg;
	logic [`CCT_NUM_EVENTS-1:0]   msk_reg;
	logic [`CCT_NUM_EVENTS-1:0]   ev_set;
	logic [`CCT_NUM_EVENTS-1:0]   ev_en;

	// Both write channels taken together, once the last answer is gone
	assign wr_fire = awvalid & wvalid & ~bvalid_reg;
	assign awready = wr_fire;
	assign wready  = wr_fire;
	assign wr_idx  = awaddr[`CCT_AW-1:2];
	assign wd      = wdata[7:0];
	assign wbe     = wstrb[0];
	assign rd_idx  = araddr[`CCT_AW-1:2];
	assign arready = ~rvalid_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign rvalid  = rvalid_reg;
	assign rresp   = rresp_reg;
	assign rdata   = rdata_reg;

	// Write response, error outside the map or on a misaligned address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `CCT_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			if (awaddr[1:0] == 2'h0 && wr_idx >= `CCT_IDX_SC && wr_idx <= `CCT_IDX_LAST) begin
				bresp_reg <= `CCT_RESP_OKAY;
			end else begin
				bresp_reg <= `CCT_RESP_SLVERR;
			end
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read data merge, only one source is non-zero
	always_comb begin
		rd_byte = rd_tm[0] | rd_tm[1] | rd_ch[0] | rd_ch[1] | rd_ch[2] | rd_ch[3];
		if (rd_idx == `CCT_IDX_IRQ_STS) begin
			rd_byte = {2'h0, sts_reg};
		end else if (rd_idx == `CCT_IDX_IRQ_MSK) begin
			rd_byte = {2'h0, msk_reg};
		end
	end

	// Read response; reads have no side effect on any state
	// read leaves count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `CCT_RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end else if (arvalid && arready) begin
			rvalid_reg <= 1'b1;
			if (araddr[1:0] == 2'h0 && rd_idx >= `CCT_IDX_SC && rd_idx <= `CCT_IDX_LAST) begin
				rresp_reg <= `CCT_RESP_OKAY;
				rdata_reg <= {24'h00_0000, rd_byte};
			end else begin
				rresp_reg <= `CCT_RESP_SLVERR;
				rdata_reg <= 32'h0000_0000;
			end
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------

	// Sticky flags, write one to clear, a new event wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sts_reg <= '0;
		end else if (wr_fire && wbe && wr_idx == `CCT_IDX_IRQ_STS) begin
			sts_reg <= (sts_reg & ~wd[`CCT_NUM_EVENTS-1:0]) | ev_set;
		end else begin
			sts_reg <= sts_reg | ev_set;
		end
	end

	// Mask register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msk_reg <= '0;
		end else if (wr_fire && wbe && wr_idx == `CCT_IDX_IRQ_MSK) begin
			msk_reg <= wd[`CCT_NUM_EVENTS-1:0];
		end
	end

	// Level interrupt, gated by mask and per-source enable
	assign irq = |(sts_reg & msk_reg & ev_en);

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	logic [15:0] cnt_reg  [`CCT_NUM_TIMERS];
	logic [15:0] mod_reg  [`CCT_NUM_TIMERS];
	logic [6:0]  pre_reg  [`CCT_NUM_TIMERS];
	logic [2:0]  ps_reg   [`CCT_NUM_TIMERS];
	logic        stop_reg [`CCT_NUM_TIMERS];
	logic        oie_reg  [`CCT_NUM_TIMERS];
	logic        step     [`CCT_NUM_TIMERS];
	logic        ovf      [`CCT_NUM_TIMERS];
	logic [15:0] cnt_next [`CCT_NUM_TIMERS];
	logic        buf_pwm  [`CCT_NUM_TIMERS];

	for (genvar t = 0; t < `CCT_NUM_TIMERS; t++) begin : g_tim
		localparam logic [7:0] BASE = 8'(`CCT_IDX_SC + t * `CCT_TIMER_STRIDE);
		localparam logic [7:0] OFS  = 8'(t * `CCT_TIMER_STRIDE);
		logic       w_sc;
		logic       trst;
		logic [6:0] pmask;

		assign w_sc  = wr_fire && wbe && wr_idx == BASE;
		assign trst  = w_sc && wd[`CCT_SC_RST];
		assign pmask = 7'((7'h01 << ps_reg[t]) - 7'h01);
		assign step[t] = !stop_reg[t] && ps_reg[t] != `CCT_PS_OFF
			&& (pre_reg[t] & pmask) == pmask;
		assign cnt_next[t] = (cnt_reg[t] == mod_reg[t]) ? 16'h0000 : cnt_reg[t] + 16'h0001;
		assign ovf[t] = step[t] && !trst && cnt_reg[t] == mod_reg[t];
		assign ev_set[3*t] = ovf[t];
		assign ev_en[3*t]  = oie_reg[t];

		// Control bits
		// stop bit
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				stop_reg[t] <= 1'b1;
				oie_reg[t]  <= 1'b0;
				ps_reg[t]   <= 3'h0;
			end else if (w_sc) begin
				oie_reg[t]  <= wd[`CCT_SC_IE];
				stop_reg[t] <= wd[`CCT_SC_STOP];
				ps_reg[t]   <= wd[2:0];
			end
		end

		// Modulo value, byte written
		// modulo all ones
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				mod_reg[t] <= `CCT_MOD_RESET;
			end else if (wr_fire && wbe && wr_idx == `CCT_IDX_MODH + OFS) begin
				mod_reg[t][15:8] <= wd;
			end else if (wr_fire && wbe && wr_idx == `CCT_IDX_MODL + OFS) begin
				mod_reg[t][7:0] <= wd;
			end
		end

		// Prescaler and counter
		// 16-bit up-counter
		always_ff @(posedge aclk) begin
			if (!aresetn || trst) begin
				pre_reg[t] <= 7'h00;
				cnt_reg[t] <= 16'h0000;
			end else begin
				pre_reg[t] <= pre_reg[t] + 7'h01;
				if (step[t]) begin
					cnt_reg[t] <= cnt_next[t];
				end
			end
		end

		// Timer register reads
		always_comb begin
			rd_tm[t] = 8'h00;
			if (rd_idx == BASE) begin
				rd_tm[t] = {sts_reg[3*t], oie_reg[t], stop_reg[t], 2'h0, ps_reg[t]};
			end else if (rd_idx == `CCT_IDX_CNTH + OFS) begin
				rd_tm[t] = cnt_reg[t][15:8];
			end else if (rd_idx == `CCT_IDX_CNTL + OFS) begin
				rd_tm[t] = cnt_reg[t][7:0];
			end else if (rd_idx == `CCT_IDX_MODH + OFS) begin
				rd_tm[t] = mod_reg[t][15:8];
			end else if (rd_idx == `CCT_IDX_MODL + OFS) begin
				rd_tm[t] = mod_reg[t][7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Channels, index j = 2 * timer + channel
	// ----------------------------------------------------------------
	logic [6:0]  ctl_reg  [4];
	logic [15:0] val_reg  [4];
	logic [15:0] act_reg  [4];
	logic        pout_reg [4];
	logic        s1_reg   [4];
	logic        s2_reg   [4];
	logic        prev_reg [4];

	for (genvar j = 0; j < 4; j++) begin : g_ch
		localparam int         T    = j / 2;
		localparam int         C    = j % 2;
		localparam logic [7:0] SCI  = 8'(`CCT_IDX_SC0 + T * `CCT_TIMER_STRIDE
			+ C * `CCT_CH_STRIDE);
		cct_pkg::cct_chmode_type mode;
		logic        w_ctl;
		logic        cap;
		logic        match;
		logic [15:0] cmp_val;
		logic [1:0]  els;

		assign els   = ctl_reg[j][3:2];
		assign w_ctl = wr_fire && wbe && wr_idx == SCI;

		// Mode decode; the second channel idles under buffered PWM
		always_comb begin
			if (els == 2'h0 || (C == 1 && buf_pwm[T])) begin
				mode = cct_pkg::CCT_CH_OFF;
			end else if (ctl_reg[j][`CCT_CH_MSB]) begin
				mode = cct_pkg::CCT_CH_PWM_BUF;
			end else if (ctl_reg[j][`CCT_CH_MSA]) begin
				mode = cct_pkg::CCT_CH_COMPARE;
			end else begin
				mode = cct_pkg::CCT_CH_CAPTURE;
			end
		end

		if (C == 0) begin : g_buf
			assign buf_pwm[T] = mode == cct_pkg::CCT_CH_PWM_BUF;
		end

		// Pin synchroniser and edge history
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				s1_reg[j]   <= 1'b0;
				s2_reg[j]   <= 1'b0;
				prev_reg[j] <= 1'b0;
			end else begin
				s1_reg[j]   <= chan_pin_i[j];
				s2_reg[j]   <= s1_reg[j];
				prev_reg[j] <= s2_reg[j];
			end
		end

		assign cap = mode == cct_pkg::CCT_CH_CAPTURE
			&& ((els[0] && s2_reg[j] && !prev_reg[j])
			|| (els[1] && !s2_reg[j] && prev_reg[j]));
		assign cmp_val = (mode == cct_pkg::CCT_CH_PWM_BUF) ? act_reg[j] : val_reg[j];
		assign match = (mode == cct_pkg::CCT_CH_COMPARE || mode == cct_pkg::CCT_CH_PWM_BUF)
			&& step[T] && cnt_next[T] == cmp_val;
		assign ev_set[3*T+1+C] = cap || match;
		assign ev_en[3*T+1+C]  = ctl_reg[j][`CCT_SC_IE];

		// Channel control, mode bit B exists on channel 0 only
		// channels cleared
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ctl_reg[j] <= 7'h00;
			end else if (w_ctl) begin
				ctl_reg[j] <= (C == 1) ? (wd[6:0] & 7'h5f) : wd[6:0];
			end
		end

		// Channel value; capture wins over a software write
		// capture latch
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				val_reg[j] <= 16'h0000;
			end else if (cap) begin
				val_reg[j] <= cnt_reg[T];
			end else if (wr_fire && wbe && wr_idx == SCI + 8'h01) begin
				val_reg[j][15:8] <= wd;
			end else if (wr_fire && wbe && wr_idx == SCI + 8'h02) begin
				val_reg[j][7:0] <= wd;
			end
		end

		// Buffered compare value loads only at overflow
		// buffered and unbuffered
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				act_reg[j] <= 16'h0000;
			end else if (mode != cct_pkg::CCT_CH_PWM_BUF || ovf[T]) begin
				act_reg[j] <= val_reg[j];
			end
		end

		// Pin level; full duty suppresses the compare action
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pout_reg[j] <= 1'b0;
			end else if (match && !ctl_reg[j][`CCT_CH_MAX]) begin
				case (els)
					2'h1:    pout_reg[j] <= !pout_reg[j];
					2'h2:    pout_reg[j] <= 1'b0;
					default: pout_reg[j] <= 1'b1;
				endcase
			end else if (ovf[T] && ctl_reg[j][`CCT_CH_TOV]
				&& mode != cct_pkg::CCT_CH_OFF && mode != cct_pkg::CCT_CH_CAPTURE) begin
				pout_reg[j] <= !pout_reg[j];
			end
		end

		// Pin sharing with the port
		// shared port pins
		always_comb begin
			if (mode == cct_pkg::CCT_CH_COMPARE || mode == cct_pkg::CCT_CH_PWM_BUF) begin
				chan_pin_o[j]  = pout_reg[j];
				chan_pin_oe[j] = 1'b1;
			end else if (mode == cct_pkg::CCT_CH_CAPTURE) begin
				chan_pin_o[j]  = 1'b0;
				chan_pin_oe[j] = 1'b0;
			end else begin
				chan_pin_o[j]  = port_out[j];
				chan_pin_oe[j] = port_oe[j];
			end
		end

		// Channel register reads
		always_comb begin
			rd_ch[j] = 8'h00;
			if (rd_idx == SCI) begin
				rd_ch[j] = {sts_reg[3*T+1+C], ctl_reg[j]};
			end else if (rd_idx == SCI + 8'h01) begin
				rd_ch[j] = val_reg[j][15:8];
			end else if (rd_idx == SCI + 8'h02) begin
				rd_ch[j] = val_reg[j][7:0];
			end
		end
	end

endmodule : cct_timer

// [verification/cct_timer_monitor.sv]
`timescale 1ns/1ns
`include "cct_defs.svh"

module cct_timer_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        irq,
	input wire logic [3:0]  chan_pin_oe
);
	// ----
	// Bus and reset checks
	// ----
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_aw_take;
		awready == (awvalid && wvalid && !bvalid) && wready == awready;
	endproperty
	a_aw_take: assert property (p_aw_take) else $error("write accept wrong");

	property p_b_ans;
		awvalid && awready |=> bvalid;
	endproperty
	a_b_ans: assert property (p_b_ans) else $error("no write answer");

	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");

	property p_b_drop;
		bvalid && bready |=> !bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("write answer stuck");

	property p_r_ans;
		arvalid && arready |=> rvalid;
	endproperty
	a_r_ans: assert property (p_r_ans) else $error("no read answer");

	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data moved");

	property p_r_data;
		rvalid |-> rdata[31:8] == 24'h0 && (rresp == `CCT_RESP_OKAY || rdata == 32'h0);
	endproperty
	a_r_data: assert property (p_r_data) else $error("read data bad");

	property p_rst_idle;
		$rose(aresetn) |-> !bvalid && !rvalid && !irq;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");

	// Main scenarios reached
	c_write: cover property (awvalid && awready);
	c_read: cover property (rvalid && rready);
	c_irq: cover property ($rose(irq));
	c_drive: cover property (|chan_pin_oe);
endmodule : cct_timer_monitor

// [verification/cct_pin_model.sv]
`timescale 1ns/1ns

module cct_pin_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [3:0] flip,
	input  wire logic [3:0] chan_pin_o,
	input  wire logic [3:0] chan_pin_oe,
	output logic [3:0]      chan_pin_i
);
	logic [3:0] src_reg;

	// Event sources, one edge per request
	always_ff @(posedge aclk) begin
		if (!aresetn)
			src_reg <= 4'h0;
		else
			src_reg <= src_reg ^ flip;
	end

	// Driving party owns the wire
	assign chan_pin_i = (chan_pin_oe & chan_pin_o) | (~chan_pin_oe & src_reg);
endmodule : cct_pin_model

// [verification/cct_timer_tb.sv]
`timescale 1ns/1ns
`include "cct_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch at %0t: got %h exp %h", $time, g, e); end end

module cct_timer_tb;
	// ----
	// Signals
	// ----
	localparam logic [7:0] sts_i = `CCT_IDX_IRQ_STS;
	localparam logic [7:0] sc1_i = `CCT_IDX_SC0 + `CCT_CH_STRIDE;
	logic               aclk = 1'h0;
	logic               aresetn = 1'h0;
	logic [`CCT_AW-1:0] awaddr = '0;
	logic [`CCT_AW-1:0] araddr = '0;
	logic [31:0]        wdata = '0;
	logic [31:0]        rdata;
	logic               awvalid = 1'h0;
	logic               wvalid = 1'h0;
	logic               bready = 1'h0;
	logic               arvalid = 1'h0;
	logic               rready = 1'h0;
	logic [3:0]         port_out = 4'h0;
	logic [3:0]         port_oe = 4'h0;
	logic [3:0]         flip = 4'h0;
	logic [3:0]         chan_pin_i, chan_pin_o, chan_pin_oe;
	logic [1:0]         bresp, rresp, rd_r, wr_r;
	logic               awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0]         rd_d, cap_v;
	int                 err_total = 0;
	int                 tests_run = 0;
	logic [7:0]         cnt;

	// 250 MHz clock
	always #2 aclk = ~aclk;

	cct_timer dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.port_out(port_out), .port_oe(port_oe), .chan_pin_i(chan_pin_i),
		.chan_pin_o(chan_pin_o), .chan_pin_oe(chan_pin_oe), .irq(irq));
	cct_pin_model pin_u (.aclk(aclk), .aresetn(aresetn), .flip(flip),
		.chan_pin_o(chan_pin_o), .chan_pin_oe(chan_pin_oe), .chan_pin_i(chan_pin_i));

	// ----
	// Bus tasks
	// ----
	// Write: address, data and response ready offered together, held until taken
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(posedge aclk);
		awaddr  <= {i, 2'h0};
		wdata   <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'h0;
		wvalid  <= 1'h0;
		while (!bvalid) @(posedge aclk);
		wr_r = bresp;
		bready <= 1'h0;
	endtask : wr

	// Read: ready raised once data stands, so the slave must hold it a cycle
	task automatic rd(input logic [7:0] i);
		@(posedge aclk);
		araddr  <= {i, 2'h0};
		arvalid <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		while (!rvalid) @(posedge aclk);
		rready <= 1'h1;
		@(posedge aclk);
		rd_d = rdata[7:0];
		rd_r = rresp;
		rready <= 1'h0;
	endtask : rd

	task automatic cr(input logic [7:0] i, input logic [7:0] e);
		rd(i);
		`CHK(rd_r, `CCT_RESP_OKAY)
		`CHK(rd_d, e)
	endtask : cr

	task automatic w(input int k);
		repeat (k) @(negedge aclk);
	endtask : w

	// One edge on a channel pin
	task automatic ev(input int j);
		@(posedge aclk);
		flip[j] <= 1'h1;
		@(posedge aclk);
		flip <= 4'h0;
		w(6);
	endtask : ev

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	// Hang guard
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		$display("mismatch at %0t: timeout", $time);
		tally_and_finish;
	end

	// ----
	// Tests
	// ----
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		cr(`CCT_IDX_SC, 8'h20);
		cr(`CCT_IDX_MODL, 8'hff);
		cr(`CCT_IDX_CNTH, 8'h00);
		cr(`CCT_IDX_SC0, 8'h00);
		cr(`CCT_IDX_SC + `CCT_TIMER_STRIDE, 8'h20);
		rd(8'h00);
		`CHK(rd_r, `CCT_RESP_SLVERR)
		wr(8'h00, 8'h5a);
		`CHK(wr_r, `CCT_RESP_SLVERR)
		$display("test reset done");
		wr(`CCT_IDX_MODH, 8'h00);
		wr(`CCT_IDX_MODL, 8'h09);
		wr(`CCT_IDX_SC, 8'h10);
		repeat (9) begin
			rd(`CCT_IDX_CNTL);
			`CHK(rd_d <= 8'h09, 1'h1)
		end
		wr(`CCT_IDX_SC, 8'h20);
		rd(sts_i);
		`CHK(rd_d[0], 1'h1)
		wr(sts_i, 8'hff);
		rd(`CCT_IDX_CNTL);
		cap_v = rd_d;
		w(9);
		cr(`CCT_IDX_CNTL, cap_v);
		wr(`CCT_IDX_SC, 8'h30);
		cr(`CCT_IDX_SC, 8'h20);
		cr(`CCT_IDX_CNTL, 8'h00);
		$display("test modulo done");
		wr(`CCT_IDX_MODL, 8'hff);
		for (int ps = 7; ps >= 0; ps--) begin
			wr(`CCT_IDX_SC, 8'h10 | 8'(ps));
			w(40);
			wr(`CCT_IDX_SC, 8'h20 | 8'(ps));
			rd(`CCT_IDX_CNTL);
			cnt = 8'((ps == 7) ? 0 : 43 >> ps);
			`CHK(rd_d + 8'h2 - 8'(cnt) <= 8'h4, 1'h1)
		end
		cap_v = rd_d;
		cr(`CCT_IDX_CNTL + `CCT_TIMER_STRIDE, 8'h00);
		$display("test prescale done");
		wr(`CCT_IDX_IRQ_MSK, 8'h02);
		for (int m = 1; m < 4; m++) begin
			wr(`CCT_IDX_SC0, 8'h40 | 8'(m << 2));
			wr(sts_i, 8'hff);
			ev(0);
			rd(sts_i);
			`CHK(rd_d[1], 1'(m & 1))
			w(1);
			`CHK(irq, 1'(m & 1))
			wr(sts_i, 8'hff);
			ev(0);
			rd(sts_i);
			`CHK(rd_d[1], 1'(m >> 1))
		end
		cr(`CCT_IDX_CH0L, cap_v);
		cr(`CCT_IDX_CH0H, 8'h00);
		wr(`CCT_IDX_IRQ_MSK, 8'h00);
		w(1);
		`CHK(irq, 1'h0)
		wr(`CCT_IDX_IRQ_MSK, 8'h02);
		w(1);
		`CHK(irq, 1'h1)
		wr(sts_i, 8'h02);
		w(1);
		`CHK(irq, 1'h0)
		$display("test capture done");
		wr(`CCT_IDX_SC0, 8'h00);
		wr(`CCT_IDX_MODL, 8'h09);
		wr(`CCT_IDX_CH0L + `CCT_CH_STRIDE, 8'h05);
		wr(`CCT_IDX_SC, 8'h10);
		wr(sc1_i, 8'h1c);
		w(12);
		`CHK({chan_pin_oe[1], chan_pin_o[1]}, 2'h3)
		wr(sc1_i, 8'h18);
		w(12);
		`CHK({chan_pin_oe[1], chan_pin_o[1]}, 2'h2)
		for (int k = 0; k < 2; k++) begin
			wr(sc1_i, k ? 8'h1f : 8'h14);
			w(12);
			cnt = 8'(chan_pin_o[1]);
			w(10);
			`CHK(chan_pin_o[1], ~1'(cnt))
		end
		$display("test compare done");
		wr(`CCT_IDX_CH0L, 8'h03);
		for (int k = 0; k < 2; k++) begin
			wr(k ? `CCT_IDX_SC0 : sc1_i, k ? 8'h2a : 8'h1a);
			w(20);
			cnt = 8'h00;
			repeat (10) begin
				w(1);
				cnt += chan_pin_o[k ? 0 : 1];
			end
			`CHK(cnt, k ? 3 : 5)
		end
		@(posedge aclk);
		port_out <= 4'ha;
		port_oe <= 4'he;
		w(2);
		`CHK({chan_pin_oe[3:2], chan_pin_o[3:2]}, 4'he)
		$display("test pwm done");
		tally_and_finish;
	end
endmodule : cct_timer_tb

bind cct_timer cct_timer_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.bresp(bresp),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.rresp(rresp), .irq(irq), .chan_pin_oe(chan_pin_oe));
